// ===== wpf_defs.svh
`ifndef WPF_DEFS_SVH
`define WPF_DEFS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define WPF_CLK_HZ 250000000
`define WPF_PERIOD_S 6
`define WPF_PERIOD_CYC (`WPF_PERIOD_S * `WPF_CLK_HZ)
`define WPF_BAUD 9600
`define WPF_BAUD_DIV (`WPF_CLK_HZ / `WPF_BAUD)
`define WPF_NULL_REPEAT 3
// ----------------------------------------
// register word addresses and fields
// ----------------------------------------
`define WPF_A_CTRL 5'h00
`define WPF_A_DIV 5'h01
`define WPF_A_ID 5'h02
`define WPF_A_DATE 5'h03
`define WPF_A_TIME 5'h04
`define WPF_A_STAT 5'h05
`define WPF_A_PKT 5'h06
`define WPF_A_VAL 5'h10
`define WPF_A_VAL_END 5'h1E
`define WPF_C_HS 0
`define WPF_C_GAS 1
`define WPF_C_PPM 2
`define WPF_C_PC 3
`define WPF_C_SEND 4
`define WPF_DIV_RST 32'h00000001
`define WPF_PPM_PER_UNIT 32'h00000064
`define WPF_PKT_MAX 32'hEE6B2800
`define WPF_NITEMS 14
`define WPF_SRC_PKT 8'h0E
// ----------------------------------------
// characters and program lengths
// ----------------------------------------
`define WPF_NULL_STR "&&\0150111-9999\015!!\015"
`define WPF_NULL_LEN 7'h10
`define WPF_CR 8'h0D
`define WPF_LF 8'h0A
`define WPF_DATA_ITEMS_END 7'h43
`endif

// ===== wpf_pkg.sv
package wpf_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_FETCH = 4'b0010, ST_DIG = 4'b0100, ST_SEND = 4'b1000
  } wpf_state_t;
  typedef enum logic [2:0] {
    OP_CHR = 3'h0, OP_NUM = 3'h1, OP_CODE = 3'h2, OP_NIB = 3'h3,
    OP_BYT = 3'h4, OP_SKIP = 3'h5, OP_END = 3'h6
  } wpf_op_t;
  typedef enum logic [1:0] {K_NULL = 2'h0, K_DATA = 2'h1, K_HOST = 2'h2} wpf_kind_t;

  // type code of each item slot, in send order
  function automatic logic [13:0] code_of(input logic [3:0] i);
    case (i)
      4'h0: code_of = 14'h008C;
      4'h1: code_of = 14'h04BC;
      4'h2: code_of = 14'h04BD;
      4'h3: code_of = 14'h04BE;
      4'h4: code_of = 14'h04BF;
      4'h5: code_of = 14'h04C0;
      4'h6: code_of = 14'h04C1;
      4'h7: code_of = 14'h04C2;
      4'h8: code_of = 14'h04C6;
      4'h9: code_of = 14'h04C9;
      4'hA: code_of = 14'h0722;
      4'hB: code_of = 14'h008A;
      4'hC: code_of = 14'h008B;
      default: code_of = 14'h006E;
    endcase
  endfunction
endpackage

// ===== wpf_packet_formatter.sv
// Function
// R1 - host packet starts with the common header, items follow it
// R2 - host packet ends with CR then LF
// R3 - header order: start char, identifier, date, time, packet number, then items
// R4 - fields comma separated; item is four-digit code then ASCII float
// R5 - code 0110 carries hole depth in feet
// R6 - packet number steps by one, wraps to zero past four billion
// R7 - one recorder transmission every six seconds
// R8 - recorder link is 9600 baud, 8 data bits, no parity, 1 stop
// R9 - handshake select zero sends the null handshake sequence
// R10 - gas enabled: send gas only after null packet lock
// R11 - gas disabled: only null packets keep the link alive
// R12 - item order 0140, 1212-1218, 1222, 1225, 1826, 0138, 0139
// R13 - total gas is divided by the divisor setting before sending
// R14 - unit select 0 sends gas units, 1 sends ppm
// R15 - lag items 0138 and 0139 only when a computer is connected
// R16 - transmission opens with && and closes with !!, items space separated
// R17 - link starts by itself once the cable is attached
// R18 - null packet: opener, 0111-9999, closer, each line ended by CR
// R19 - null packet repeats until the recorder locks
// R20 - period counted in clock cycles, restarted at each launch
`include "wpf_defs.svh"
module wpf_packet_formatter #(
  parameter int unsigned PERIOD_CYC = `WPF_PERIOD_CYC,
  parameter int unsigned BAUD_DIV = `WPF_BAUD_DIV,
  parameter int unsigned NULL_REPEAT = `WPF_NULL_REPEAT
)(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic cable_present_i,
  output logic rec_tx_o,
  output logic [7:0] host_data_o,
  output logic host_valid_o,
  input wire logic host_ready_i,
  output wpf_pkg::wpf_kind_t kind_o
);
  import wpf_pkg::*;

  localparam logic [127:0] NSTR = `WPF_NULL_STR;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [3:0] ctrl_r;
  logic [31:0] div_r, id_r, date_r, time_r, pkt_r, rdata_r, rd_mux;
  logic [31:0] val_mem [0:`WPF_NITEMS-1];
  logic ack_r, host_pend_r, cab_s1_r, cab_s2_r, locked;
  logic [7:0] null_cnt_r;
  wpf_state_t st_r, st_nxt;
  wpf_kind_t kind_r, kind_nxt, rec_kind;
  logic [9:0] tx_sh_r;
  logic [3:0] tx_bits_r;

  wire req = avs_read_i | avs_write_i;
  wire wr_go = avs_write_i & ack_r;
  wire is_val = (avs_address_i >= `WPF_A_VAL) && (avs_address_i < `WPF_A_VAL_END);
  wire ctrl_send = wr_go && avs_address_i == `WPF_A_CTRL && avs_writedata_i[`WPF_C_SEND];
  wire hs_skip = ctrl_r[`WPF_C_HS];
  wire gas_en = ctrl_r[`WPF_C_GAS];
  wire ppm = ctrl_r[`WPF_C_PPM];
  wire pc_conn = ctrl_r[`WPF_C_PC];
  assign avs_waitrequest_o = req & ~ack_r;
  assign avs_readdata_o = rdata_r;

  always_comb begin
    rd_mux = 32'h00000000;
    if (is_val) begin
      rd_mux = val_mem[avs_address_i[3:0]];
    end else begin
      case (avs_address_i)
        `WPF_A_CTRL: rd_mux = {28'h0000000, ctrl_r};
        `WPF_A_DIV: rd_mux = div_r;
        `WPF_A_ID: rd_mux = id_r;
        `WPF_A_DATE: rd_mux = date_r;
        `WPF_A_TIME: rd_mux = time_r;
        `WPF_A_STAT: rd_mux = {28'h0000000, st_r != ST_IDLE, host_pend_r, cab_s2_r, locked};
        `WPF_A_PKT: rd_mux = pkt_r;
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_r <= 4'h0;
      div_r <= `WPF_DIV_RST;
      id_r <= 32'h00000000;
      date_r <= 32'h00000000;
      time_r <= 32'h00000000;
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        rdata_r <= rd_mux;
      end
      if (wr_go) begin
        case (avs_address_i)
          `WPF_A_CTRL: ctrl_r <= avs_writedata_i[3:0];
          `WPF_A_DIV: div_r <= avs_writedata_i;
          `WPF_A_ID: id_r <= avs_writedata_i;
          `WPF_A_DATE: date_r <= avs_writedata_i;
          `WPF_A_TIME: time_r <= avs_writedata_i;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_go && is_val) begin
      val_mem[avs_address_i[3:0]] <= avs_writedata_i;
    end
  end

  // ----------------------------------------
  // cable sense, period, launch
  // ----------------------------------------
  logic [31:0] per_cnt_r;
  wire due = per_cnt_r >= 32'(PERIOD_CYC - 1);
  wire launch_rec = st_r == ST_IDLE && due && cab_s2_r; // R17
  wire launch_host = st_r == ST_IDLE && !launch_rec && host_pend_r;
  assign locked = hs_skip || null_cnt_r >= 8'(NULL_REPEAT); // R9 R19
  assign rec_kind = (gas_en && locked) ? K_DATA : K_NULL; // R10 R11

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cab_s1_r <= 1'b0;
      cab_s2_r <= 1'b0;
      per_cnt_r <= 32'(PERIOD_CYC - 1);
      host_pend_r <= 1'b0;
    end else begin
      cab_s1_r <= cable_present_i;
      cab_s2_r <= cab_s1_r;
      host_pend_r <= ctrl_send | (host_pend_r & ~launch_host);
      if (launch_rec) begin
        per_cnt_r <= 32'h00000000; // R7 R20
      end else if (!due) begin
        per_cnt_r <= per_cnt_r + 32'h00000001;
      end
    end
  end

  // ----------------------------------------
  // character program
  // ----------------------------------------
  logic [6:0] tp_r, tp_nxt;
  logic [31:0] num_r, num_nxt, num_src, base;
  logic [3:0] k_r, k_nxt;
  logic fix_r, fix_nxt, sta_r, sta_nxt, innum_r, innum_nxt;
  logic [7:0] ch_r, ch_nxt, arg;
  wpf_op_t op;
  wire [6:0] dtp = tp_r - 7'h02;
  wire [3:0] item_i = 4'(dtp / 7'h05);
  wire [2:0] item_s = 3'(dtp % 7'h05);
  wire incl = item_i < 4'hB || pc_conn; // R15
  wire [3:0] nidx = 4'hF - tp_r[3:0];
  wire [31:0] gas_q = val_mem[0] / ((div_r == 32'h00000000) ? 32'h00000001 : div_r); // R13
  wire [3:0] nib = arg[4] ? time_r[{arg[2:0], 2'b00} +: 4] : date_r[{arg[2:0], 2'b00} +: 4];
  wire [7:0] lit_ch = (op == OP_NIB) ? {4'h3, nib} : (op == OP_BYT) ? id_r[{arg[1:0], 3'b000} +: 8] : arg;

  always_comb begin
    op = OP_END;
    arg = 8'h00;
    unique case (kind_r)
      K_NULL: if (tp_r < `WPF_NULL_LEN) begin
        op = OP_CHR; // R18
        arg = NSTR[{nidx, 3'b000} +: 8];
      end
      K_DATA: if (tp_r < 7'h02) begin
        op = OP_CHR; // R16
        arg = 8'h26;
      end else if (tp_r < `WPF_DATA_ITEMS_END) begin
        op = OP_CHR;
        arg = {4'h0, item_i}; // R12
        case (item_s)
          3'h0: begin op = incl ? OP_CHR : OP_SKIP; arg = 8'h20; end
          3'h1: op = OP_CODE;
          3'h2: op = OP_NUM;
          3'h3: arg = 8'h2E;
          default: arg = 8'h30;
        endcase
      end else begin
        op = OP_CHR;
        case (tp_r)
          7'h43: arg = 8'h20;
          7'h44, 7'h45: arg = 8'h21; // R16
          7'h46: arg = `WPF_CR;
          default: op = OP_END;
        endcase
      end
      default: begin
        op = OP_CHR;
        case (tp_r)
          7'h00: arg = 8'h5E; // R1 R3
          7'h01, 7'h06, 7'h11, 7'h1A, 7'h1C, 7'h21: arg = 8'h2C; // R4
          7'h02, 7'h03, 7'h04, 7'h05: begin op = OP_BYT; arg = 8'(7'h05 - tp_r); end
          7'h07, 7'h08, 7'h09, 7'h0A: begin op = OP_NIB; arg = 8'(7'h0E - tp_r); end
          7'h0C, 7'h0D: begin op = OP_NIB; arg = 8'(7'h0F - tp_r); end
          7'h0F, 7'h10: begin op = OP_NIB; arg = 8'(7'h10 - tp_r); end
          7'h12, 7'h13: begin op = OP_NIB; arg = 8'(7'h27 - tp_r); end
          7'h15, 7'h16: begin op = OP_NIB; arg = 8'(7'h28 - tp_r); end
          7'h18, 7'h19: begin op = OP_NIB; arg = 8'(7'h29 - tp_r); end
          7'h0B, 7'h0E: arg = 8'h2F;
          7'h14, 7'h17: arg = 8'h3A;
          7'h1B: begin op = OP_NUM; arg = `WPF_SRC_PKT; end
          7'h1D: begin op = OP_CODE; arg = 8'h0D; end // R5
          7'h1E: begin op = OP_NUM; arg = 8'h0D; end
          7'h1F: arg = 8'h2E;
          7'h20: arg = 8'h30;
          7'h22: arg = `WPF_CR; // R2
          7'h23: arg = `WPF_LF;
          default: op = OP_END;
        endcase
      end
    endcase
  end

  // ----------------------------------------
  // number source and decimal digits
  // ----------------------------------------
  function automatic logic [3:0] dec_digit(input logic [31:0] v, input logic [3:0] k);
    logic [31:0] p;
    p = 32'h00000001;
    for (int j = 0; j < 9; j++) begin
      if (4'(j) < k) begin
        p = p * 32'h0000000A;
      end
    end
    dec_digit = 4'((v / p) % 32'h0000000A);
  endfunction

  assign base = (arg[3:0] == 4'h0) ? gas_q : val_mem[(arg[3:0] > 4'hD) ? 4'h0 : arg[3:0]];
  assign num_src = (arg == `WPF_SRC_PKT) ? pkt_r :
    (ppm && arg < 8'h08) ? 32'(base * `WPF_PPM_PER_UNIT) : base; // R14
  wire [3:0] cur_d = dec_digit(num_r, k_r);
  wire emit = sta_r || cur_d != 4'h0 || k_r == 4'h0 || (fix_r && k_r < 4'h4);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  wire tx_idle = tx_bits_r == 4'h0;
  wire accept = (kind_r == K_HOST) ? host_ready_i : tx_idle;
  wire tx_load = st_r == ST_SEND && kind_r != K_HOST && tx_idle;
  wire prog_end = st_r == ST_FETCH && op == OP_END;
  assign host_valid_o = st_r == ST_SEND && kind_r == K_HOST;
  assign host_data_o = ch_r;
  assign kind_o = kind_r;

  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    tp_nxt = tp_r;
    num_nxt = num_r;
    k_nxt = k_r;
    fix_nxt = fix_r;
    sta_nxt = sta_r;
    innum_nxt = innum_r;
    ch_nxt = ch_r;
    unique case (st_r)
      ST_IDLE: if (launch_rec || launch_host) begin
        st_nxt = ST_FETCH;
        tp_nxt = 7'h00;
        kind_nxt = launch_rec ? rec_kind : K_HOST;
      end
      ST_FETCH: case (op)
        OP_END: st_nxt = ST_IDLE;
        OP_SKIP: tp_nxt = tp_r + 7'h05;
        OP_NUM, OP_CODE: begin
          st_nxt = ST_DIG;
          innum_nxt = 1'b1;
          sta_nxt = 1'b0;
          k_nxt = 4'h9;
          fix_nxt = op == OP_CODE; // R4
          num_nxt = (op == OP_CODE) ? {18'h00000, code_of(arg[3:0])} : num_src;
        end
        default: begin
          st_nxt = ST_SEND;
          ch_nxt = lit_ch;
        end
      endcase
      ST_DIG: if (emit) begin
        st_nxt = ST_SEND;
        ch_nxt = {4'h3, cur_d};
        sta_nxt = 1'b1;
      end else begin
        k_nxt = k_r - 4'h1;
      end
      ST_SEND: if (accept) begin
        if (innum_r && k_r != 4'h0) begin
          st_nxt = ST_DIG;
          k_nxt = k_r - 4'h1;
        end else begin
          st_nxt = ST_FETCH;
          innum_nxt = 1'b0;
          tp_nxt = tp_r + 7'h01;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= ST_IDLE;
      kind_r <= K_NULL;
      tp_r <= 7'h00;
      num_r <= 32'h00000000;
      k_r <= 4'h0;
      {fix_r, sta_r, innum_r} <= 3'h0;
      ch_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      tp_r <= tp_nxt;
      num_r <= num_nxt;
      k_r <= k_nxt;
      {fix_r, sta_r, innum_r} <= {fix_nxt, sta_nxt, innum_nxt};
      ch_r <= ch_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pkt_r <= 32'h00000000;
      null_cnt_r <= 8'h00;
    end else begin
      if (prog_end && kind_r == K_HOST) begin
        pkt_r <= (pkt_r >= `WPF_PKT_MAX) ? 32'h00000000 : pkt_r + 32'h00000001; // R6
      end
      if (!cab_s2_r) begin
        null_cnt_r <= 8'h00;
      end else if (prog_end && kind_r == K_NULL && !locked) begin
        null_cnt_r <= null_cnt_r + 8'h01; // R19
      end
    end
  end

  // ----------------------------------------
  // recorder serial transmitter, 8N1
  // ----------------------------------------
  logic [15:0] baud_cnt_r;
  assign rec_tx_o = tx_sh_r[0];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_sh_r <= 10'h3FF;
      tx_bits_r <= 4'h0;
      baud_cnt_r <= 16'h0000;
    end else if (tx_load) begin
      tx_sh_r <= {1'b1, ch_r, 1'b0}; // R8
      tx_bits_r <= 4'hA;
      baud_cnt_r <= 16'h0000;
    end else if (!tx_idle) begin
      if (baud_cnt_r == 16'(BAUD_DIV - 1)) begin
        baud_cnt_r <= 16'h0000;
        tx_sh_r <= {1'b1, tx_sh_r[9:1]};
        tx_bits_r <= tx_bits_r - 4'h1;
      end else begin
        baud_cnt_r <= baud_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence s_host_go;
    launch_host;
  endsequence
  sequence s_host_caret;
    host_valid_o && host_data_o == 8'h5E;
  endsequence
  property p_host_start;
    s_host_go |-> ##[2:3] s_host_caret;
  endproperty
  a_host_start: assert property (p_host_start) else $error("host packet not opened by caret"); // R3
  property p_crlf;
    host_valid_o && host_ready_i && host_data_o == `WPF_CR |=> ##[1:3] (host_valid_o && host_data_o == `WPF_LF);
  endproperty
  a_crlf: assert property (p_crlf) else $error("CR not followed by LF"); // R2
  property p_pkt;
    prog_end && kind_r == K_HOST |=> pkt_r == (($past(pkt_r) >= `WPF_PKT_MAX) ? 32'h0 : $past(pkt_r) + 32'h1);
  endproperty
  a_pkt: assert property (p_pkt) else $error("packet number step wrong"); // R6
  property p_period;
    launch_rec |=> per_cnt_r == 32'h0 ##1 per_cnt_r == 32'h1 || due;
  endproperty
  a_period: assert property (p_period) else $error("period count not restarted"); // R20
  property p_gas_off;
    launch_rec && !gas_en |=> kind_r == K_NULL;
  endproperty
  a_gas_off: assert property (p_gas_off) else $error("data sent with gas disabled"); // R11
  property p_handshake;
    launch_rec && !hs_skip && null_cnt_r == 8'h00 |=> kind_r == K_NULL;
  endproperty
  a_handshake: assert property (p_handshake) else $error("handshake skipped"); // R9
  property p_open;
    launch_rec && rec_kind == K_DATA |=> ##1 (st_r == ST_SEND && ch_r == 8'h26);
  endproperty
  a_open: assert property (p_open) else $error("transmission not opened by ampersand"); // R16
  property p_uart;
    tx_load |=> !rec_tx_o && tx_bits_r == 4'hA;
  endproperty
  a_uart: assert property (p_uart) else $error("start bit missing"); // R8
  property p_div;
    st_r == ST_FETCH && op == OP_NUM && arg == 8'h00 && !ppm |=> num_r == $past(gas_q);
  endproperty
  a_div: assert property (p_div) else $error("total gas not divided"); // R13
endmodule

// ===== wpf_rec_model.sv
// ----------------------------------------
// drilling_recorder side: 8N1 receiver that splits the stream into transmissions
// ----------------------------------------
module wpf_rec_model #(
  parameter int unsigned BAUD_DIV = 4
)(
  input wire logic clk_i,
  input wire logic line_i
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt = 0;
  int unsigned frm_err = 0;
  string cur = "";
  string ch = " ";
  string tx_q[$];
  int unsigned start_q[$];
  logic [7:0] b;

  // sampled on the falling edge, where the line has settled
  always @(negedge clk_i) cnt <= cnt + 1;

  // runs at the fixed BAUD_DIV rate it is given: LSB first, start low, stop high
  initial forever begin
    @(negedge clk_i);
    if (line_i === 1'b0) begin
      if (cur.len() == 0) start_q.push_back(cnt);
      repeat (BAUD_DIV / 2) @(negedge clk_i);
      if (line_i !== 1'b0) frm_err++;
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(negedge clk_i);
        b[i] = line_i;
      end
      repeat (BAUD_DIV) @(negedge clk_i);
      if (line_i !== 1'b1) frm_err++;
      ch[0] = b;
      cur = {cur, ch};
      if (cur.len() >= 3 && cur.substr(cur.len() - 3, cur.len() - 1) == "!!\015") begin
        tx_q.push_back(cur);
        cur = "";
      end
    end
  end
endmodule

// ===== wpf_packet_formatter_bench.sv
module wpf_packet_formatter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import wpf_pkg::*;
  localparam int unsigned PER = 8000;
  localparam int unsigned BD = 4;
  localparam string NUL = "&&\0150111-9999\015!!\015";
  logic clk, rst, rd, wr, cable, hrdy, tx, hval, wreq;
  logic [4:0] adr;
  logic [31:0] wdat, rdat, q, t0;
  logic [7:0] hdat;
  logic [31:0] cyc = 32'h0;
  wpf_kind_t kind;
  int error_cnt = 0;
  int num_checks = 0;
  string hs = "";
  string hc = " ";
  int unsigned vals[14];
  int unsigned codes[13] = '{140, 1212, 1213, 1214, 1215, 1216, 1217, 1218, 1222, 1225, 1826, 138, 139};

  wpf_packet_formatter #(.PERIOD_CYC(PER), .BAUD_DIV(BD), .NULL_REPEAT(3)) wpf_packet_formatter_i (
    .clk_i(clk), .reset_i(rst), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .cable_present_i(cable), .rec_tx_o(tx), .host_data_o(hdat), .host_valid_o(hval),
    .host_ready_i(hrdy), .kind_o(kind)
  );
  wpf_rec_model #(.BAUD_DIV(BD)) wpf_rec_model_i (.clk_i(clk), .line_i(tx));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // ----------------------------------------
  // host sink: stalls one cycle in four
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    hrdy <= cyc[1:0] != 2'h0;
  end
  always @(negedge clk) begin
    if (hval === 1'b1 && hrdy === 1'b1) begin
      hc[0] = hdat;
      hs = {hs, hc};
    end
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic chk_s(input string seen, input string exp, input string msg);
    chk({31'h0, seen == exp}, 32'h1, msg);
  endtask

  task automatic fail(input string msg);
    chk(32'h0, 32'h1, msg);
    wrap_up;
  endtask

  // request held until waitrequest is sampled low at a rising edge, data taken and released at that edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (i == 50) fail("bus timeout");
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string msg);
    bus(1'b0, a, 32'h0);
    chk(q, exp, msg);
  endtask

  task automatic wait_tx(input int k);
    for (int i = 0; i < 3 * PER; i++) begin
      @(posedge clk);
      if (wpf_rec_model_i.tx_q.size() > k) return;
    end
    fail("recorder timeout");
  endtask

  task automatic host_pkt(input int k);
    int i;
    hs = "";
    bus(1'b1, 5'h00, 32'h1E);
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (hs.len() > 0 && hs[hs.len() - 1] == 8'h0A) break;
    end
    if (i == 3000) fail("host timeout");
    chk_s(hs, $sformatf("^,AB12,2008/04/20,13:11:13,%0d,01101234.0,\015\n", k), "host packet");
    rd_chk(5'h06, k + 1, "packet number");
  endtask

  function automatic string data_s(input bit ppm, input bit pc);
    string s;
    int unsigned v;
    s = "&&";
    for (int i = 0; i < (pc ? 13 : 11); i++) begin
      v = (i == 0) ? vals[i] / 4 : vals[i];
      if (ppm && i < 8) v = v * 100;
      s = {s, $sformatf(" %04d%0d.0", codes[i], v)};
    end
    return {s, " !!\015"};
  endfunction

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 5'h00;
    wdat = 32'h0;
    cable = 1'b0;
    for (int i = 0; i < 14; i++) vals[i] = (i == 0) ? 100 : (i == 13) ? 1234 : 10 * i + 3;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(5'h00, 32'h0, "ctrl reset");
    rd_chk(5'h01, 32'h1, "divisor reset");
    bus(1'b1, 5'h06, 32'h55);
    rd_chk(5'h06, 32'h0, "packet number read only");
    bus(1'b1, 5'h08, 32'hFF);
    rd_chk(5'h08, 32'h0, "unmapped reads zero");
    for (int i = 0; i < 14; i++) bus(1'b1, 5'h10 + i[4:0], vals[i]);
    bus(1'b1, 5'h01, 32'h4);
    rd_chk(5'h01, 32'h4, "divisor");
    bus(1'b1, 5'h02, 32'h41423132);
    bus(1'b1, 5'h03, 32'h20080420);
    bus(1'b1, 5'h04, 32'h00131113);
    bus(1'b1, 5'h00, 32'h2);
    rd_chk(5'h10, 32'h64, "total gas value");
    @(posedge clk);
    cable <= 1'b1;
    t0 = wpf_rec_model_i.cnt;
    wait_tx(0);
    chk({31'h0, wpf_rec_model_i.start_q[0] - t0 <= 10}, 32'h1, "start on cable");
    for (int k = 0; k < 3; k++) begin
      wait_tx(k);
      chk_s(wpf_rec_model_i.tx_q[k], NUL, "null packet");
      chk({30'h0, kind}, {30'h0, K_NULL}, "null kind");
    end
    wait_tx(3);
    chk_s(wpf_rec_model_i.tx_q[3], data_s(0, 0), "gas data");
    chk({30'h0, kind}, {30'h0, K_DATA}, "data kind");
    chk(wpf_rec_model_i.start_q[1] - wpf_rec_model_i.start_q[0], PER, "period");
    chk(wpf_rec_model_i.start_q[3] - wpf_rec_model_i.start_q[2], PER, "period");
    bus(1'b0, 5'h05, 32'h0);
    chk(q & 32'h3, 32'h3, "locked and cable");
    host_pkt(0);
    host_pkt(1);
    chk({30'h0, kind}, {30'h0, K_HOST}, "host kind");
    wait_tx(4);
    chk_s(wpf_rec_model_i.tx_q[4], data_s(1, 1), "ppm and lag data");
    chk(wpf_rec_model_i.start_q[4] - wpf_rec_model_i.start_q[3], PER, "period");
    bus(1'b1, 5'h00, 32'h0);
    wait_tx(5);
    chk_s(wpf_rec_model_i.tx_q[5], NUL, "gas off keeps null");
    @(posedge clk);
    cable <= 1'b0;
    repeat (20) @(posedge clk);
    bus(1'b1, 5'h00, 32'h3);
    @(posedge clk);
    cable <= 1'b1;
    wait_tx(6);
    chk_s(wpf_rec_model_i.tx_q[6], data_s(0, 0), "handshake skipped");
    repeat (20) @(posedge clk);
    chk({31'h0, tx}, 32'h1, "line idle high");
    chk(wpf_rec_model_i.frm_err, 32'h0, "framing");
    wrap_up;
  end
endmodule
